// ### logic/adcseq_pkg.sv
/*
 * Shared constants of the converter mode sequencer: register offsets, bit
 * positions, reset values, conversion lengths and the sequencer states.
 * Assumes nothing of its surroundings; it is compiled before the design.
 */
package adcseq_pkg;

   // ==========================================================================
   // Register byte offsets on the APB slave.
   // ==========================================================================
   localparam logic [11:0] OFS_SGL_CTRL   = 12'h000;
   localparam logic [11:0] OFS_SGL_CFG    = 12'h004;
   localparam logic [11:0] OFS_SCN_CTRL   = 12'h008;
   localparam logic [11:0] OFS_SCN_CFG    = 12'h00C;
   localparam logic [11:0] OFS_APPROX     = 12'h010;
   localparam logic [11:0] OFS_CMP_RES    = 12'h014;
   localparam logic [5:0]  RES_PAGE       = 6'h01;

   // ==========================================================================
   // Bit positions in the mode registers.
   // ==========================================================================
   localparam int B_SCAN_CONT = 1;
   localparam int B_HW_SRC    = 2;
   localparam int B_TRIG_KIND = 3;
   localparam int B_REQ_KIND  = 4;
   localparam int B_DONE      = 5;
   localparam int B_STOP      = 6;
   localparam int B_START     = 7;
   localparam int B_CMP_MODE  = 8;
   localparam int B_RATE      = 9;
   localparam int B_CHAN_LO   = 12;
   localparam int B_GRP_LO    = 0;

   // ==========================================================================
   // Group size codes and reset values.
   // ==========================================================================
   localparam logic [1:0]  GRP_FOUR    = 2'h0;
   localparam logic [1:0]  GRP_EIGHT   = 2'h1;
   localparam logic [3:0]  LAST_FOUR   = 4'h3;
   localparam logic [3:0]  LAST_EIGHT  = 4'h7;
   localparam logic [3:0]  LAST_SIXTN  = 4'hF;
   localparam logic [3:0]  CHAN_ZERO   = 4'h0;
   localparam logic [3:0]  CHAN_STEP   = 4'h1;
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;

   // ==========================================================================
   // Conversion lengths in bus clock cycles.
   // ==========================================================================
   localparam int CONV_NORMAL = 299;
   localparam int CONV_DOUBLE = 173;
   localparam int CMP_NORMAL  = 47;
   localparam int CMP_DOUBLE  = 29;

   // Gray codes along idle, single, scan.
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SINGLE = 2'b01,
      ST_SCAN   = 2'b11
   } adcseq_state_t;

endpackage

// ### logic/adcseq_top.sv
/*
 * Mode sequencer of a successive-approximation converter with an APB slave.
 * Assumes an analog core outside that samples the channel on conv_channel
 * while conv_active is high and presents sample_value and compare_high, valid
 * in the last cycle of each operation. All inputs are synchronous to pclk.
 */
// Overview of operation
// - Single mode: one operation on selected channel.
// - Scan converts four, eight or sixteen channels.
// - Single scan stops; continuous repeats until stop.
// - Scan type from control, group size from configuration.
// - Scan groups start at zero, ascending order.
// - Channel result lands in same-numbered register.
// - Completed scan pass raises completion request.
// - Forced single stores conversion or comparison result.
// - Forced single resumes scan at cancelled channel.
// - Software start during scan forces single conversion.
// - Approximation write during scan starts comparison.
// - Selected hardware trigger forces single during scan.
// - Software scan start during single queues scan.
// - Hardware scan trigger during single queues scan.
// - Shared hardware trigger: single then scan.
// - Restart request during single restarts it.
// - Restart request during scan restarts channel zero.
// - Per-mode bit picks interrupt or DMA request.
// - Source select: pin when zero, event line one.
// - Single start with stop in one write: stop wins; scan stop is taken from the scan configuration write.
// - Single done flag high except while running.
module adcseq_top #(
   parameter int CONV_N_LEN = adcseq_pkg::CONV_NORMAL,
   parameter int CONV_D_LEN = adcseq_pkg::CONV_DOUBLE,
   parameter int CMP_N_LEN  = adcseq_pkg::CMP_NORMAL,
   parameter int CMP_D_LEN  = adcseq_pkg::CMP_DOUBLE,
   parameter int RES_W      = 10
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              ext_conv_trigger_pin,
   input  wire logic              event_line_three,
   input  wire logic [RES_W-1:0]  sample_value,
   input  wire logic              compare_high,
   output logic                   conv_active,
   output logic                   conv_compare,
   output logic      [3:0]        conv_channel,
   output logic                   irq_pulse,
   output logic                   dma_pulse
);

   // ==========================================================================
   // Elaboration checks.
   // ==========================================================================
   localparam int CNT_W = 16;

   if (CONV_N_LEN < 1 || CONV_D_LEN < 1 || CMP_N_LEN < 1 || CMP_D_LEN < 1
       || CONV_N_LEN >= 2**CNT_W || CONV_D_LEN >= 2**CNT_W || CMP_N_LEN >= 2**CNT_W
       || CMP_D_LEN >= 2**CNT_W || RES_W < 1 || RES_W > 16) begin : g_param_chk
      $error("adcseq_top: length or width parameter out of range.");
   end

   localparam logic [CNT_W-1:0] LEN_CN = CNT_W'(CONV_N_LEN - 1);
   localparam logic [CNT_W-1:0] LEN_CD = CNT_W'(CONV_D_LEN - 1);
   localparam logic [CNT_W-1:0] LEN_MN = CNT_W'(CMP_N_LEN - 1);
   localparam logic [CNT_W-1:0] LEN_MD = CNT_W'(CMP_D_LEN - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   // ==========================================================================
   // Register state.
   // ==========================================================================
   logic                     sgl_hw_src_q;
   logic                     sgl_trig_hw_q;
   logic                     sgl_req_dma_q;
   logic                     sgl_cmp_mode_q;
   logic                     sgl_rate_q;
   logic [3:0]               sgl_chan_q;
   logic                     scn_hw_src_q;
   logic                     scn_trig_hw_q;
   logic                     scn_req_dma_q;
   logic                     scn_cont_q;
   logic [1:0]               scn_grp_q;
   logic [RES_W-1:0]         approx_value_reg_q;
   logic [15:0]              cmp_res_q;
   logic [RES_W-1:0]         channel_result_reg [16];

   adcseq_pkg::adcseq_state_t state_q;
   logic [CNT_W-1:0]         cnt_q;
   logic [3:0]               scan_chan_q;
   logic                     resume_q;
   logic                     scan_queued_q;
   logic                     ext_prev_q;
   logic                     evt_prev_q;

   // ==========================================================================
   // APB decode.
   // ==========================================================================
   logic       wr_acc;
   logic       setup_rd;
   logic       res_hit;
   logic       known;
   logic       wr_sgl_ctrl;
   logic       wr_scn_ctrl;
   logic       wr_scn_cfg;
   logic       wr_approx;

   assign pready   = clk_en;
   assign wr_acc   = psel & penable & pwrite & clk_en;
   assign setup_rd = psel & ~penable & ~pwrite & clk_en;
   assign res_hit  = (paddr[11:6] == adcseq_pkg::RES_PAGE) && (paddr[1:0] == 2'h0);
   assign known    = res_hit
                     || paddr == adcseq_pkg::OFS_SGL_CTRL
                     || paddr == adcseq_pkg::OFS_SGL_CFG
                     || paddr == adcseq_pkg::OFS_SCN_CTRL
                     || paddr == adcseq_pkg::OFS_SCN_CFG
                     || paddr == adcseq_pkg::OFS_APPROX
                     || paddr == adcseq_pkg::OFS_CMP_RES;
   assign pslverr  = psel & penable & ~known;

   assign wr_sgl_ctrl = wr_acc && paddr == adcseq_pkg::OFS_SGL_CTRL;
   assign wr_scn_ctrl = wr_acc && paddr == adcseq_pkg::OFS_SCN_CTRL;
   assign wr_scn_cfg  = wr_acc && paddr == adcseq_pkg::OFS_SCN_CFG;
   assign wr_approx   = wr_acc && paddr == adcseq_pkg::OFS_APPROX;

   // ==========================================================================
   // Start, stop and trigger events.
   // ==========================================================================
   logic       ext_edge;
   logic       evt_edge;
   logic       sgl_hw_trig;
   logic       scn_hw_trig;
   logic       sgl_stop;
   logic       sgl_go;
   logic       scn_stop;
   logic       scn_go;
   logic [3:0] last_chan;
   logic       op_end;

   assign ext_edge = ext_conv_trigger_pin & ~ext_prev_q;
   assign evt_edge = event_line_three & ~evt_prev_q;

   assign sgl_hw_trig = sgl_trig_hw_q & (sgl_hw_src_q ? evt_edge : ext_edge);
   assign scn_hw_trig = scn_trig_hw_q & (scn_hw_src_q ? evt_edge : ext_edge);

   assign sgl_stop = wr_sgl_ctrl & pwdata[adcseq_pkg::B_STOP];
   assign sgl_go   = (wr_sgl_ctrl & pwdata[adcseq_pkg::B_START] & ~sgl_trig_hw_q
                      & ~pwdata[adcseq_pkg::B_STOP])
                     | sgl_hw_trig
                     | (wr_approx & sgl_cmp_mode_q & state_q == adcseq_pkg::ST_SCAN);
   assign scn_stop = wr_scn_cfg & pwdata[adcseq_pkg::B_STOP];
   assign scn_go   = (wr_scn_ctrl & pwdata[adcseq_pkg::B_START] & ~scn_trig_hw_q)
                     | scn_hw_trig;

   always_comb begin
      case (scn_grp_q)
         adcseq_pkg::GRP_FOUR:  last_chan = adcseq_pkg::LAST_FOUR;
         adcseq_pkg::GRP_EIGHT: last_chan = adcseq_pkg::LAST_EIGHT;
         default:               last_chan = adcseq_pkg::LAST_SIXTN;
      endcase
   end

   assign op_end = (state_q != adcseq_pkg::ST_IDLE) && cnt_q == CNT_ZERO;

   function automatic logic [CNT_W-1:0] sgl_len(input logic cmp, input logic dbl);
      if (cmp) begin
         sgl_len = dbl ? LEN_MD : LEN_MN;
      end else begin
         sgl_len = dbl ? LEN_CD : LEN_CN;
      end
   endfunction

   // ==========================================================================
   // Configuration registers.
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sgl_hw_src_q       <= 1'b0;
         sgl_trig_hw_q      <= 1'b0;
         sgl_req_dma_q      <= 1'b0;
         sgl_cmp_mode_q     <= 1'b0;
         sgl_rate_q         <= 1'b0;
         sgl_chan_q         <= adcseq_pkg::CHAN_ZERO;
         scn_hw_src_q       <= 1'b0;
         scn_trig_hw_q      <= 1'b0;
         scn_req_dma_q      <= 1'b0;
         scn_cont_q         <= 1'b0;
         scn_grp_q          <= adcseq_pkg::GRP_FOUR;
         approx_value_reg_q <= '0;
      end else if (wr_acc) begin
         if (paddr == adcseq_pkg::OFS_SGL_CTRL) begin
            sgl_hw_src_q  <= pwdata[adcseq_pkg::B_HW_SRC];
            sgl_trig_hw_q <= pwdata[adcseq_pkg::B_TRIG_KIND];
            sgl_req_dma_q <= pwdata[adcseq_pkg::B_REQ_KIND];
         end
         if (paddr == adcseq_pkg::OFS_SGL_CFG) begin
            sgl_cmp_mode_q <= pwdata[adcseq_pkg::B_CMP_MODE];
            sgl_rate_q     <= pwdata[adcseq_pkg::B_RATE];
            sgl_chan_q     <= pwdata[adcseq_pkg::B_CHAN_LO +: 4];
         end
         if (paddr == adcseq_pkg::OFS_SCN_CTRL) begin
            scn_cont_q    <= pwdata[adcseq_pkg::B_SCAN_CONT];
            scn_hw_src_q  <= pwdata[adcseq_pkg::B_HW_SRC];
            scn_trig_hw_q <= pwdata[adcseq_pkg::B_TRIG_KIND];
            scn_req_dma_q <= pwdata[adcseq_pkg::B_REQ_KIND];
         end
         if (paddr == adcseq_pkg::OFS_SCN_CFG) scn_grp_q <= pwdata[adcseq_pkg::B_GRP_LO +: 2];
         if (paddr == adcseq_pkg::OFS_APPROX) approx_value_reg_q <= pwdata[RES_W-1:0];
      end
   end

   // ==========================================================================
   // Trigger edge history.
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_q <= 1'b0;
         evt_prev_q <= 1'b0;
      end else if (clk_en) begin
         ext_prev_q <= ext_conv_trigger_pin;
         evt_prev_q <= event_line_three;
      end
   end

   // ==========================================================================
   // Sequencer.
   // ==========================================================================
   // A forced single keeps the cancelled scan channel in scan_chan_q, so the
   // resume needs no extra save register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q       <= adcseq_pkg::ST_IDLE;
         cnt_q         <= CNT_ZERO;
         scan_chan_q   <= adcseq_pkg::CHAN_ZERO;
         resume_q      <= 1'b0;
         scan_queued_q <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            adcseq_pkg::ST_IDLE: begin
               if (sgl_go & ~sgl_stop) begin
                  state_q       <= adcseq_pkg::ST_SINGLE;
                  cnt_q         <= sgl_len(sgl_cmp_mode_q, sgl_rate_q);
                  resume_q      <= 1'b0;
                  scan_queued_q <= scn_go;
               end else if (scn_go & ~scn_stop) begin
                  state_q     <= adcseq_pkg::ST_SCAN;
                  cnt_q       <= sgl_rate_q ? LEN_CD : LEN_CN;
                  scan_chan_q <= adcseq_pkg::CHAN_ZERO;
               end
            end
            adcseq_pkg::ST_SINGLE: begin
               if (sgl_stop || (op_end && !sgl_go)) begin
                  scan_queued_q <= 1'b0;
                  cnt_q         <= sgl_rate_q ? LEN_CD : LEN_CN;
                  if (resume_q) begin
                     state_q <= adcseq_pkg::ST_SCAN;
                  end else if (scan_queued_q | scn_go) begin
                     state_q     <= adcseq_pkg::ST_SCAN;
                     scan_chan_q <= adcseq_pkg::CHAN_ZERO;
                  end else begin
                     state_q <= adcseq_pkg::ST_IDLE;
                  end
               end else begin
                  cnt_q <= sgl_go ? sgl_len(sgl_cmp_mode_q, sgl_rate_q) : cnt_q - 1'b1;
                  if (scn_go) scan_queued_q <= 1'b1;
               end
            end
            adcseq_pkg::ST_SCAN: begin
               if (scn_stop) begin
                  state_q <= adcseq_pkg::ST_IDLE;
               end else if (sgl_go) begin
                  state_q  <= adcseq_pkg::ST_SINGLE;
                  cnt_q    <= sgl_len(sgl_cmp_mode_q, sgl_rate_q);
                  resume_q <= 1'b1;
               end else if (scn_go) begin
                  cnt_q       <= sgl_rate_q ? LEN_CD : LEN_CN;
                  scan_chan_q <= adcseq_pkg::CHAN_ZERO;
               end else if (op_end) begin
                  cnt_q <= sgl_rate_q ? LEN_CD : LEN_CN;
                  if (scan_chan_q != last_chan) begin
                     scan_chan_q <= scan_chan_q + adcseq_pkg::CHAN_STEP;
                  end else if (scn_cont_q) begin
                     scan_chan_q <= adcseq_pkg::CHAN_ZERO;
                  end else begin
                     state_q <= adcseq_pkg::ST_IDLE;
                  end
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: state_q <= adcseq_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Result storage.
   // ==========================================================================
   logic sgl_done_ev;
   logic scn_done_ev;

   assign sgl_done_ev = state_q == adcseq_pkg::ST_SINGLE && op_end && !sgl_go && !sgl_stop;
   assign scn_done_ev = state_q == adcseq_pkg::ST_SCAN && op_end && !sgl_go && !scn_go
                        && !scn_stop && scan_chan_q == last_chan;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_res_q <= '0;
         for (int i = 0; i < 16; i++) begin
            channel_result_reg[i] <= '0;
         end
      end else if (clk_en) begin
         if (sgl_done_ev) begin
            if (sgl_cmp_mode_q) begin
               cmp_res_q[sgl_chan_q] <= compare_high;
            end else begin
               channel_result_reg[sgl_chan_q] <= sample_value;
            end
         end
         if (state_q == adcseq_pkg::ST_SCAN && op_end && !sgl_go && !scn_go && !scn_stop) begin
            channel_result_reg[scan_chan_q] <= sample_value;
         end
      end
   end

   // ==========================================================================
   // Completion requests and status outputs.
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pulse <= 1'b0;
         dma_pulse <= 1'b0;
      end else if (clk_en) begin
         irq_pulse <= (sgl_done_ev & ~sgl_req_dma_q) | (scn_done_ev & ~scn_req_dma_q);
         dma_pulse <= (sgl_done_ev & sgl_req_dma_q) | (scn_done_ev & scn_req_dma_q);
      end else begin
         irq_pulse <= 1'b0;
         dma_pulse <= 1'b0;
      end
   end

   assign conv_active  = state_q != adcseq_pkg::ST_IDLE;
   assign conv_compare = state_q == adcseq_pkg::ST_SINGLE && sgl_cmp_mode_q;
   assign conv_channel = (state_q == adcseq_pkg::ST_SINGLE) ? sgl_chan_q : scan_chan_q;

   // ==========================================================================
   // Read data, captured in the setup phase so the access phase sees a flop.
   // ==========================================================================
   logic [31:0] rd_word;

   always_comb begin
      rd_word = adcseq_pkg::RST_WORD;
      if (res_hit) begin
         rd_word[RES_W-1:0] = channel_result_reg[paddr[5:2]];
      end else begin
         case (paddr)
            adcseq_pkg::OFS_SGL_CTRL: begin
               rd_word[adcseq_pkg::B_HW_SRC]    = sgl_hw_src_q;
               rd_word[adcseq_pkg::B_TRIG_KIND] = sgl_trig_hw_q;
               rd_word[adcseq_pkg::B_REQ_KIND]  = sgl_req_dma_q;
               rd_word[adcseq_pkg::B_DONE]      = state_q != adcseq_pkg::ST_SINGLE;
            end
            adcseq_pkg::OFS_SGL_CFG: begin
               rd_word[adcseq_pkg::B_CMP_MODE]      = sgl_cmp_mode_q;
               rd_word[adcseq_pkg::B_RATE]          = sgl_rate_q;
               rd_word[adcseq_pkg::B_CHAN_LO +: 4]  = sgl_chan_q;
            end
            adcseq_pkg::OFS_SCN_CTRL: begin
               rd_word[adcseq_pkg::B_SCAN_CONT] = scn_cont_q;
               rd_word[adcseq_pkg::B_HW_SRC]    = scn_hw_src_q;
               rd_word[adcseq_pkg::B_TRIG_KIND] = scn_trig_hw_q;
               rd_word[adcseq_pkg::B_REQ_KIND]  = scn_req_dma_q;
               rd_word[adcseq_pkg::B_DONE]      = state_q != adcseq_pkg::ST_SCAN;
            end
            adcseq_pkg::OFS_SCN_CFG: rd_word[adcseq_pkg::B_GRP_LO +: 2] = scn_grp_q;
            adcseq_pkg::OFS_APPROX:  rd_word[RES_W-1:0] = approx_value_reg_q;
            adcseq_pkg::OFS_CMP_RES: rd_word[15:0] = cmp_res_q;
            default:                 rd_word = adcseq_pkg::RST_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= adcseq_pkg::RST_WORD;
      end else if (setup_rd) begin
         prdata <= rd_word;
      end
   end

endmodule

// ### test/adcseq_core_model.sv
/* Behavioural analog core answering the sequencer.
   Assumes values are sampled in the last cycle of each operation. */
module adcseq_core_model (
   input  wire logic       pclk,
   input  wire logic       conv_active,
   input  wire logic [3:0] conv_channel,
   output logic      [9:0] sample_value,
   output logic            compare_high
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========
   // Outside a run the lines toggle so a stale value cannot pass.
   logic flip_q = 1'b0;
   always @(posedge pclk) flip_q <= !flip_q;
   assign sample_value = conv_active ? {6'h15, conv_channel} : {10{flip_q}};
   assign compare_high = conv_active ? conv_channel[0] : flip_q;
endmodule

// ### test/adcseq_properties.sv
/* Port checker of the converter mode sequencer.
   Assumes it is bound to adcseq_top and sees its ports only. */
module adcseq_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        conv_active,
   input wire logic        conv_compare,
   input wire logic        irq_pulse,
   input wire logic        dma_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ========
   // Write decodes
   logic      sgl_hw_q, scn_hw_q;
   wire logic wr_ok  = psel && penable && pwrite && clk_en;
   wire logic sgl_go = wr_ok && paddr == 12'h000 && pwdata[7] && !sgl_hw_q;
   wire logic scn_go = wr_ok && paddr == 12'h008 && pwdata[7] && !scn_hw_q;
   // A start obeys the trigger kind already stored, not the one in the same write.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sgl_hw_q <= 1'b0;
         scn_hw_q <= 1'b0;
      end else begin
         if (wr_ok && paddr == 12'h000) sgl_hw_q <= pwdata[3];
         if (wr_ok && paddr == 12'h008) scn_hw_q <= pwdata[3];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_irq_single: assert property (irq_pulse |=> !irq_pulse)
      else $error("irq pulse longer than one cycle");
   chk_dma_single: assert property (dma_pulse |=> !dma_pulse)
      else $error("dma pulse longer than one cycle");
   chk_one_kind: assert property (!(irq_pulse && dma_pulse))
      else $error("irq and dma pulse together");
   chk_pulse_after_run: assert property ($rose(irq_pulse) |-> $past(conv_active))
      else $error("completion without a run");
   chk_single_start: assert property (sgl_go && !pwdata[6] |=> conv_active)
      else $error("single start ignored");
   chk_stop_wins: assert property (sgl_go && pwdata[6] && !conv_active |=> !conv_active)
      else $error("start with stop began a run");
   chk_scan_start: assert property (scn_go |=> conv_active)
      else $error("scan start ignored");
   chk_cmp_in_run: assert property (conv_compare |-> conv_active)
      else $error("comparison outside a run");
   chk_cmp_done_req: assert property ($fell(conv_compare) && !$past(wr_ok)
      |-> irq_pulse || dma_pulse) else $error("comparison ended without a request");
   cov_irq: cover property (irq_pulse);
   cov_dma: cover property (dma_pulse);
   cov_cmp: cover property (conv_compare);
endmodule

bind adcseq_top adcseq_properties i_adcseq_properties (.pclk, .presetn, .clk_en, .psel,
   .penable, .pwrite, .paddr, .pwdata, .conv_active, .conv_compare, .irq_pulse, .dma_pulse);

// ### test/tb_top.sv
/* Register level bench of the converter mode sequencer.
   Assumes short operation lengths and the core model beside it. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        ext_conv_trigger_pin = 1'b0, event_line_three = 1'b0;
   logic        pready, pslverr, conv_active, conv_compare, compare_high, irq_pulse, dma_pulse;
   logic        last_err;
   logic [9:0]  sample_value;
   logic [3:0]  conv_channel;
   int          num_errors = 0, checks_done = 0, cyc = 0, i;
   always #2 pclk = !pclk;
   adcseq_top #(.CONV_N_LEN(6), .CONV_D_LEN(6), .CMP_N_LEN(5), .CMP_D_LEN(5)) i_adcseq_top (
      .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ext_conv_trigger_pin, .event_line_three, .sample_value,
      .compare_high, .conv_active, .conv_compare, .conv_channel, .irq_pulse, .dma_pulse);
   adcseq_core_model i_adcseq_core_model (.pclk, .conv_active, .conv_channel, .sample_value,
      .compare_high);
   // ========
   // Bus and check tasks
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      ck(r, e);
   endtask
   // Waits for a completion pulse; e is {dma, irq}.
   task automatic wp(input logic [31:0] e);
      for (int n = 0; n < 300; n++) begin
         @(negedge pclk);
         if (irq_pulse === 1'b1 || dma_pulse === 1'b1) break;
      end
      ck({dma_pulse, irq_pulse}, e);
      @(posedge pclk);
   endtask
   task automatic ca(input logic e);
      @(negedge pclk);
      ck(conv_active, e);
      @(posedge pclk);
   endtask
   task automatic cc(input logic [3:0] e);
      @(negedge pclk);
      ck(conv_channel, e);
      @(posedge pclk);
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(12'h000, 32'hC0);
      ca(1'b0);
      wr(12'h004, 32'h5000);
      wr(12'h000, 32'h80);
      rc(12'h000, 32'h0);
      wp(1);
      rc(12'h054, 32'h155);
      rc(12'h000, 32'h20);
      rc(12'h100, 32'h0);
      ck(last_err, 1'b1);
      wr(12'h00C, 32'h1);
      wr(12'h008, 32'h90);
      wp(2);
      for (i = 0; i < 8; i++) rc(12'h040 + 12'(4 * i), 32'h150 | 32'(i));
      rc(12'h060, 32'h0);
      wr(12'h00C, 32'h2);
      wr(12'h008, 32'h82);
      wp(1);
      wp(1);
      wr(12'h00C, 32'h42);
      repeat (3) @(posedge pclk);
      ca(1'b0);
      rc(12'h07C, 32'h15F);
      ck(last_err, 1'b0);
      wr(12'h008, 32'h90);
      wr(12'h004, 32'h3100);
      repeat (9) @(posedge pclk);
      wr(12'h010, 32'h155);
      wp(1);
      cc(4'h2);
      wp(2);
      rc(12'h014, 32'h8);
      wr(12'h004, 32'h0);
      wr(12'h00C, 32'h0);
      wr(12'h000, 32'h0C);
      wr(12'h008, 32'h1C);
      ext_conv_trigger_pin <= 1'b1;
      @(posedge pclk) ext_conv_trigger_pin <= 1'b0;
      @(posedge pclk);
      ca(1'b0);
      event_line_three <= 1'b1;
      @(posedge pclk) event_line_three <= 1'b0;
      wp(1);
      wp(2);
      wr(12'h000, 32'h0);
      wr(12'h008, 32'h0);
      wr(12'h000, 32'h80);
      wr(12'h008, 32'h90);
      wr(12'h000, 32'h80);
      wp(1);
      wp(2);
      wr(12'h008, 32'h90);
      repeat (9) @(posedge pclk);
      wr(12'h008, 32'h90);
      cc(4'h0);
      wr(12'h000, 32'h80);
      wp(1);
      wp(2);
      give_verdict();
   end
endmodule
